// File: design/tbsc_ctrl.sv
// Two-bank interleaved synchronous DRAM controller, top level.
// Assumes a pipelined host bus, an external registered address mux,
// an external refresh timer, and APB for the two control registers.
//
// What this block does
// - Mode word programs CAS latency three, interleaved wrap, burst of four.
// - Mode space access precharges both banks, then loads the mode register.
// - A10 high during all-bank precharge, low during mode load, via mux.
// - After configuration assert burst-ready, then honour access and refresh.
// - Burst read on precharged bank takes twelve clocks; next-address after five.
// - Alternating-bank pipelined burst reads overlap for zero-wait cache fills.
// - Bank chosen by address bit 5, so bursts stay in one bank.
// - Pipelined single access to the other bank completes in five clocks.
// - Burst write on precharged bank completes in seven clocks.
// - Pipelined burst writes complete in as few as five clocks.
// - Refresh request is latched and synchronised before bank B samples it.
// - Bank B serves a competing refresh first, then the access.
// - Address lines and strobe decoded within one clock for DRAM space.
// - Write indication sampled in request's first clock for conflict check.
// - One pending flag per bank holds a request until its access starts.
// - Per-bank write and burst flags, plus one refresh-request flag.
// - Each bank outputs a wait indication deferring conflicting starts.
// - Mux row/column select, burst-ready and next-address come from registers.
// - Two independent bank machines share host inputs and DRAM commands.
// - Top bits select DRAM space, a5 picks bank, a27 with a5 mode space.
// - Next-address allows pipelined access; burst-ready ends each transfer.
// - Each command holds the strobes at its levels for exactly one clock.
// - Data masks gate read output buffers and mask bytes on writes.
`default_nettype none
module tbsc_ctrl
  import tbsc_pkg::*;
(
  input  wire logic             core_clk,
  input  wire logic             rstn,
  input  wire tbsc_host_in_type host_in,
  input  wire logic             refresh_req,
  input  wire tbsc_apb_req_type apb_req,
  output tbsc_apb_rsp_type      apb_rsp,
  output logic                  brdy_n,
  output logic                  next_address_n,
  output tbsc_dram_cmd_type     dram_cmd,
  output logic [7:0]            dqm,
  output tbsc_mux_ctl_type      mux_ctl,
  output logic [11:0]           mode_word
);
  ////////////////////////////////////////////////////////////////////////////
  // Host address decode
  wire       space_hit = (host_in.addr[SPACE_MSB:SPACE_LSB] == DRAM_SPACE[4:1])
                         && !host_in.addr[MODE_SEL_BIT];
  wire       ads       = !host_in.ads_n;
  wire       bank_sel  = host_in.addr[BANK_SEL_BIT];
  wire       hit_a     = ads && space_hit && !bank_sel;
  wire       hit_b     = ads && space_hit && bank_sel;
  wire       hit_mode  = ads && (host_in.addr[SPACE_MSB:SPACE_LSB] == DRAM_SPACE[4:1])
                         && host_in.addr[MODE_SEL_BIT] && bank_sel;
  wire       burst_req = !host_in.cache_n;

  ////////////////////////////////////////////////////////////////////////////
  // State and flag registers
  tbsc_state_type st_a_q;
  tbsc_state_type st_a_d;
  tbsc_state_type st_b_q;
  tbsc_state_type st_b_d;
  logic           cfg_done_q;
  logic           pend_a_q;
  logic           pend_b_q;
  logic           req_wr_a_q;
  logic           req_wr_b_q;
  logic           req_bu_a_q;
  logic           req_bu_b_q;
  logic           wr_a_q;
  logic           wr_b_q;
  logic           bu_a_q;
  logic           bu_b_q;
  logic           rfrq_q;
  logic           wait_a_q;
  logic           wait_b_q;
  logic [7:0]     be_n_q;
  logic [31:0]    ctrl_q;
  logic [31:0]    prdata_q;
  logic           brdy_n_q;
  logic           na_n_q;
  logic           rd_ext_q;
  logic [7:0]     dqm_q;
  tbsc_mux_ctl_type mux_q;
  logic           rfsh_pulse;

  ////////////////////////////////////////////////////////////////////////////
  // Refresh request path
  tbsc_refresh_sync u_rfsh (
    .core_clk    (core_clk),
    .rstn        (rstn),
    .refresh_req (refresh_req & ctrl_q[CTRL_RFSH_EN]),
    .ack         (st_b_q == ST_RF8),
    .req_pulse   (rfsh_pulse)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Start conditions. The first-clock write sample decides the conflict
  // check; a pending request uses the write flag latched with it.
  wire       new_a      = hit_a && !pend_a_q;
  wire       new_b      = hit_b && !pend_b_q;
  wire       want_wr_a  = pend_a_q ? req_wr_a_q : host_in.write;
  wire       want_wr_b  = pend_b_q ? req_wr_b_q : host_in.write;
  wire       want_bu_a  = pend_a_q ? req_bu_a_q : burst_req;
  wire       want_bu_b  = pend_b_q ? req_bu_b_q : burst_req;
  wire       go_a       = (st_a_q == ST_IDLE) && (hit_a || pend_a_q) && !rfrq_q
                          && !(wait_b_q && want_wr_a);
  wire       rf_go      = (st_b_q == ST_IDLE) && rfrq_q && (st_a_q == ST_IDLE);
  wire       go_b       = (st_b_q == ST_IDLE) && (hit_b || pend_b_q) && !rfrq_q
                          && !(wait_a_q && want_wr_b);

  // Conflict window of a running access: burst read until idle, single
  // read until data is out, single write until its command is issued.
  function automatic logic busy_for_wr(input tbsc_state_type st, input logic wr,
                                       input logic bu);
    busy_for_wr = wr ? (!bu && pre_rc0(st))
                     : (bu ? (st != ST_IDLE) : pre_rc2(st));
  endfunction : busy_for_wr

  ////////////////////////////////////////////////////////////////////////////
  // Access path shared by both machines
  function automatic tbsc_state_type access_next(input tbsc_state_type st);
    case (st)
      ST_ACT:  access_next = ST_RCD0;
      ST_RCD0: access_next = ST_RCD1;
      ST_RCD1: access_next = ST_CMD;
      ST_CMD:  access_next = ST_RC0;
      ST_RC0:  access_next = ST_RC1;
      ST_RC1:  access_next = ST_RC2;
      ST_RC2:  access_next = ST_RC3;
      ST_RC3:  access_next = ST_RC4;
      default: access_next = ST_IDLE;
    endcase
  endfunction : access_next

  ////////////////////////////////////////////////////////////////////////////
  // Bank A machine: configuration sequence and bank A accesses
  always_comb begin
    case (st_a_q)
      ST_RESET: st_a_d = hit_mode ? ST_MODE0 : ST_RESET;
      ST_MODE0: st_a_d = ST_MODE1;
      ST_MODE1: st_a_d = ST_MODE2;
      ST_MODE2: st_a_d = ST_MODE3;
      ST_MODE3: st_a_d = ST_MODE4;
      ST_MODE4: st_a_d = ST_IDLE;
      ST_IDLE:  st_a_d = go_a ? ST_ACT : ST_IDLE;
      default:  st_a_d = access_next(st_a_q);
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bank B machine: refresh and bank B accesses
  always_comb begin
    case (st_b_q)
      ST_RESET: st_b_d = cfg_done_q ? ST_IDLE : ST_RESET;
      ST_IDLE:  st_b_d = rf_go ? ST_RF0 : (go_b ? ST_ACT : ST_IDLE);
      ST_RF0:   st_b_d = ST_RF1;
      ST_RF1:   st_b_d = ST_RF2;
      ST_RF2:   st_b_d = ST_RF3;
      ST_RF3:   st_b_d = ST_RF4;
      ST_RF4:   st_b_d = ST_RF5;
      ST_RF5:   st_b_d = ST_RF6;
      ST_RF6:   st_b_d = ST_RF7;
      ST_RF7:   st_b_d = ST_RF8;
      ST_RF8:   st_b_d = ST_IDLE;
      default:  st_b_d = access_next(st_b_q);
    endcase
  end

  wire start_a = (st_a_q == ST_IDLE) && (st_a_d == ST_ACT);
  wire start_b = (st_b_q == ST_IDLE) && (st_b_d == ST_ACT);

  ////////////////////////////////////////////////////////////////////////////
  // Command selection. Refresh starts only with bank A idle and bank A
  // never starts while refresh is flagged, so the sources cannot collide.
  tbsc_cmd_type cmd_sel;
  always_comb begin
    cmd_sel = CMD_NOP;
    case (st_a_q)
      ST_MODE0: cmd_sel = CMD_PRE_ALL;
      ST_MODE2: cmd_sel = CMD_MODE_LOAD;
      ST_ACT:   cmd_sel = CMD_ACTIVE;
      ST_CMD:   cmd_sel = wr_a_q ? CMD_WRITE : CMD_READ;
      default:  cmd_sel = CMD_NOP;
    endcase
    if (cmd_sel == CMD_NOP) begin
      case (st_b_q)
        ST_RF0:  cmd_sel = CMD_PRE_ALL;
        ST_RF2:  cmd_sel = CMD_REFRESH;
        ST_ACT:  cmd_sel = CMD_ACTIVE;
        ST_CMD:  cmd_sel = wr_b_q ? CMD_WRITE : CMD_READ;
        default: cmd_sel = CMD_NOP;
      endcase
    end
  end

  tbsc_cmd_issue u_cmd (
    .core_clk (core_clk),
    .rstn     (rstn),
    .cmd      (cmd_sel),
    .dram_cmd (dram_cmd)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Host handshake decode. Writes take data before the command because
  // the registered transceivers hold it; reads wait for CAS latency.
  function automatic logic bank_brdy(input tbsc_state_type st, input logic wr,
                                     input logic bu);
    if (wr) begin
      bank_brdy = bu ? (st == ST_RCD0 || st == ST_RCD1 || st == ST_CMD || st == ST_RC0)
                     : (st == ST_RCD0);
    end else begin
      bank_brdy = bu ? (st == ST_RC2 || st == ST_RC3 || st == ST_RC4)
                     : (st == ST_RC2);
    end
  endfunction : bank_brdy

  wire brdy_d  = bank_brdy(st_a_q, wr_a_q, bu_a_q) || bank_brdy(st_b_q, wr_b_q, bu_b_q)
                 || (st_a_q == ST_MODE4) || !host_in.brdy_in_n || rd_ext_q;
  wire na_d    = (st_a_q == ST_RCD1) || (st_b_q == ST_RCD1);
  wire rd_dq   = (!wr_a_q && st_a_q inside {ST_RC0, ST_RC1, ST_RC2, ST_RC3})
                 || (!wr_b_q && st_b_q inside {ST_RC0, ST_RC1, ST_RC2, ST_RC3});
  wire wr_dq_a = wr_a_q && st_a_q inside {ST_CMD, ST_RC0, ST_RC1, ST_RC2};
  wire wr_dq_b = wr_b_q && st_b_q inside {ST_CMD, ST_RC0, ST_RC1, ST_RC2};
  wire [7:0] dqm_d = rd_dq ? 8'h00 : ((wr_dq_a || wr_dq_b) ? be_n_q : DQM_OFF);
  wire col_d   = (st_a_d == ST_CMD) || (st_b_d == ST_CMD);

  ////////////////////////////////////////////////////////////////////////////
  // State, configuration and host output registers
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_a_q     <= ST_RESET;
      st_b_q     <= ST_RESET;
      cfg_done_q <= 1'b0;
      brdy_n_q   <= 1'b1;
      na_n_q     <= 1'b1;
      rd_ext_q   <= 1'b0;
      dqm_q      <= DQM_OFF;
      mux_q      <= '0;
    end else begin
      st_a_q     <= st_a_d;
      st_b_q     <= st_b_d;
      cfg_done_q <= cfg_done_q | (st_a_q == ST_MODE4);
      brdy_n_q   <= !brdy_d;
      na_n_q     <= !na_d;
      // Last read beat falls one clock past RC4, beyond the state decode
      rd_ext_q   <= (st_a_q == ST_RC4 && !wr_a_q && bu_a_q) || (st_b_q == ST_RC4 && !wr_b_q && bu_b_q);
      dqm_q      <= dqm_d;
      mux_q.col_sel   <= col_d;
      mux_q.a10_high  <= (st_a_d == ST_MODE0) || (st_b_d == ST_RF0);
      mux_q.load_mode <= (st_a_d == ST_MODE2);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pending, write, burst and refresh flags. A new request for a bank
  // with one pending is dropped, or held with the old flags if that one starts in the same cycle: the host cannot pipeline deeper.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pend_a_q   <= 1'b0;
      pend_b_q   <= 1'b0;
      req_wr_a_q <= 1'b0;
      req_wr_b_q <= 1'b0;
      req_bu_a_q <= 1'b0;
      req_bu_b_q <= 1'b0;
      rfrq_q     <= 1'b0;
    end else begin
      pend_a_q <= start_a ? (pend_a_q && hit_a) : (pend_a_q || (hit_a && cfg_done_q));
      pend_b_q <= start_b ? (pend_b_q && hit_b) : (pend_b_q || (hit_b && cfg_done_q));
      if (new_a) begin
        req_wr_a_q <= host_in.write;
        req_bu_a_q <= burst_req;
      end
      if (new_b) begin
        req_wr_b_q <= host_in.write;
        req_bu_b_q <= burst_req;
      end
      // A new timer request wins over the clear at the end of refresh
      rfrq_q <= (rfsh_pulse && cfg_done_q) || (rfrq_q && (st_b_q != ST_RF8));
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wr_a_q   <= 1'b0;
      wr_b_q   <= 1'b0;
      bu_a_q   <= 1'b0;
      bu_b_q   <= 1'b0;
      wait_a_q <= 1'b0;
      wait_b_q <= 1'b0;
      be_n_q   <= DQM_OFF;
    end else begin
      if (start_a) begin
        wr_a_q <= want_wr_a;
        bu_a_q <= want_bu_a;
      end
      if (start_b) begin
        wr_b_q <= want_wr_b;
        bu_b_q <= want_bu_b;
      end
      if (start_a || start_b) begin
        be_n_q <= host_in.be_n;
      end
      wait_a_q <= busy_for_wr(st_a_d, start_a ? want_wr_a : wr_a_q,
                              start_a ? want_bu_a : bu_a_q);
      wait_b_q <= busy_for_wr(st_b_d, start_b ? want_wr_b : wr_b_q,
                              start_b ? want_bu_b : bu_b_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave, zero wait. Read data is captured in the setup phase.
  wire        apb_setup = apb_req.psel && !apb_req.penable;
  wire        apb_acc   = apb_req.psel && apb_req.penable;
  wire        map_ctrl  = (apb_req.paddr == CTRL_OFS);
  wire        map_stat  = (apb_req.paddr == STATUS_OFS);
  wire [31:0] status_v  = {16'h0000, st_b_q, st_a_q, rfrq_q, wait_b_q, wait_a_q,
                           pend_b_q, pend_a_q, cfg_done_q};
  wire [31:0] rd_mux    = map_ctrl ? ctrl_q : (map_stat ? status_v : 32'h0000_0000);

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_q   <= CTRL_RESET;
      prdata_q <= 32'h0000_0000;
    end else begin
      if (apb_setup) begin
        prdata_q <= rd_mux;
      end
      if (apb_acc && apb_req.pwrite && map_ctrl) begin
        ctrl_q <= {31'h0000_0000, apb_req.pwdata[CTRL_RFSH_EN]};
      end
    end
  end

  assign apb_rsp.prdata  = prdata_q;
  assign apb_rsp.pready  = 1'b1;
  assign apb_rsp.pslverr = apb_acc && !map_ctrl && !map_stat;

  ////////////////////////////////////////////////////////////////////////////
  assign brdy_n         = brdy_n_q;
  assign next_address_n = na_n_q;
  assign dqm            = dqm_q;
  assign mux_ctl        = mux_q;
  assign mode_word      = MODE_WORD;
endmodule : tbsc_ctrl
`default_nettype wire

// File: inc/tbsc_pkg.sv
// Shared types and constants of the two-bank synchronous DRAM controller.
// Assumes a single 125 MHz core clock and a zero-wait APB register slave.
`default_nettype none
package tbsc_pkg;
  ////////////////////////////////////////////////////////////////////////////
  // Host address decode fields
  localparam int          HOST_AW       = 32;
  localparam logic [4:0]  DRAM_SPACE    = 5'h1c;  // a31..a28 = 1110
  localparam int          SPACE_MSB     = 31;
  localparam int          SPACE_LSB     = 28;
  localparam int          MODE_SEL_BIT  = 27;
  localparam int          BANK_SEL_BIT  = 5;      // 32-byte interleave
  ////////////////////////////////////////////////////////////////////////////
  // DRAM mode word: CAS latency 3, interleaved wrap, burst of 4
  localparam logic [2:0]  MODE_BL4      = 3'h2;
  localparam logic [0:0]  MODE_WRAP_INT = 1'h1;
  localparam logic [2:0]  MODE_CL3      = 3'h3;
  localparam logic [11:0] MODE_WORD     = {5'h00, MODE_CL3, MODE_WRAP_INT, MODE_BL4};
  ////////////////////////////////////////////////////////////////////////////
  // APB register map
  localparam logic [7:0]  CTRL_OFS      = 8'h00;
  localparam logic [7:0]  STATUS_OFS    = 8'h04;
  localparam int          CTRL_RFSH_EN  = 0;
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0001;
  localparam logic [7:0]  DQM_OFF       = 8'hff;
  ////////////////////////////////////////////////////////////////////////////
  // Bank state encoding, Gray steps along the access path
  typedef enum logic [4:0] {
    ST_IDLE  = 5'h00, ST_ACT   = 5'h01, ST_RCD0  = 5'h03, ST_RCD1  = 5'h02,
    ST_CMD   = 5'h06, ST_RC0   = 5'h07, ST_RC1   = 5'h05, ST_RC2   = 5'h04,
    ST_RC3   = 5'h0c, ST_RC4   = 5'h0d,
    ST_MODE0 = 5'h0f, ST_MODE1 = 5'h0e, ST_MODE2 = 5'h0a, ST_MODE3 = 5'h0b,
    ST_MODE4 = 5'h09,
    ST_RF0   = 5'h10, ST_RF1   = 5'h11, ST_RF2   = 5'h13, ST_RF3   = 5'h12,
    ST_RF4   = 5'h16, ST_RF5   = 5'h17, ST_RF6   = 5'h15, ST_RF7   = 5'h14,
    ST_RF8   = 5'h1c, ST_RESET = 5'h18
  } tbsc_state_type;
  typedef enum logic [2:0] {
    CMD_NOP, CMD_ACTIVE, CMD_READ, CMD_WRITE, CMD_PRE_ALL, CMD_MODE_LOAD, CMD_REFRESH
  } tbsc_cmd_type;
  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic        ads_n;
    logic [31:0] addr;
    logic        write;
    logic        cache_n;
    logic [7:0]  be_n;
    logic        brdy_in_n;
  } tbsc_host_in_type;
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
  } tbsc_dram_cmd_type;
  typedef struct packed {
    logic col_sel;
    logic a10_high;
    logic load_mode;
  } tbsc_mux_ctl_type;
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } tbsc_apb_req_type;
  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } tbsc_apb_rsp_type;
  ////////////////////////////////////////////////////////////////////////////
  // Access still before its column command
  function automatic logic pre_rc0(input tbsc_state_type st);
    pre_rc0 = (st == ST_ACT) || (st == ST_RCD0) || (st == ST_RCD1) || (st == ST_CMD);
  endfunction : pre_rc0
  // Access still before its read data is out
  function automatic logic pre_rc2(input tbsc_state_type st);
    pre_rc2 = pre_rc0(st) || (st == ST_RC0) || (st == ST_RC1);
  endfunction : pre_rc2
  function automatic tbsc_dram_cmd_type cmd_levels(input tbsc_cmd_type c);
    case (c)
      CMD_ACTIVE:    cmd_levels = 4'b0011;
      CMD_READ:      cmd_levels = 4'b0101;
      CMD_WRITE:     cmd_levels = 4'b0100;
      CMD_PRE_ALL:   cmd_levels = 4'b0010;
      CMD_MODE_LOAD: cmd_levels = 4'b0000;
      CMD_REFRESH:   cmd_levels = 4'b0001;
      default:       cmd_levels = 4'b1111;
    endcase
  endfunction : cmd_levels
endpackage : tbsc_pkg
`default_nettype wire

// File: design/tbsc_refresh_sync.sv
// Refresh request catcher: latches the timer request, synchronises it and
// gives one pulse per request. Assumes ack arrives once per served refresh.
`default_nettype none
module tbsc_refresh_sync
  import tbsc_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic rstn,
  input  wire logic refresh_req,
  input  wire logic ack,
  output logic      req_pulse
);
  logic req_q;
  logic latch_q;
  logic sync1_q;
  logic sync2_q;
  logic sync3_q;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      req_q   <= 1'b0;
      latch_q <= 1'b0;
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
    end else begin
      req_q   <= refresh_req;
      // Rising edge only, so a level still high at ack cannot stick
      latch_q <= (refresh_req & ~req_q) | (latch_q & ~ack);
      sync1_q <= latch_q;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // Edge of the synchronised level, so a held request counts only once
  assign req_pulse = sync2_q & ~sync3_q;
endmodule : tbsc_refresh_sync
`default_nettype wire

// File: design/tbsc_cmd_issue.sv
// DRAM command register: one command in, strobe levels held one clock.
// Assumes the caller presents CMD_NOP between commands.
`default_nettype none
module tbsc_cmd_issue
  import tbsc_pkg::*;
(
  input  wire logic         core_clk,
  input  wire logic         rstn,
  input  wire tbsc_cmd_type cmd,
  output tbsc_dram_cmd_type dram_cmd
);
  tbsc_dram_cmd_type cmd_q;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cmd_q <= 4'hf;
    end else begin
      cmd_q <= cmd_levels(cmd);
    end
  end

  assign dram_cmd = cmd_q;
endmodule : tbsc_cmd_issue
`default_nettype wire

// File: verif/tbsc_dram_model.sv
// DRAM side monitor: records the loaded mode word and counts refreshes.
// Assumes the command strobes of the controller top.
`default_nettype none
module tbsc_dram_model
  import tbsc_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              rstn,
  input  wire tbsc_dram_cmd_type dram_cmd,
  input  wire tbsc_mux_ctl_type  mux_ctl,
  input  wire logic [11:0]       mode_word,
  output logic [11:0]            mode_q,
  output logic [7:0]             ref_q
);
  // The external mux is registered, so load_mode leads the command by a clock
  logic lm_q;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      mode_q <= 12'h000;
      ref_q  <= 8'h00;
      lm_q   <= 1'b0;
    end else begin
      lm_q   <= mux_ctl.load_mode;
      if (dram_cmd == 4'b0000 && lm_q) mode_q <= mode_word;
      if (dram_cmd == 4'b0001) ref_q <= ref_q + 8'h01;
    end
  end
endmodule : tbsc_dram_model
`default_nettype wire

// File: verif/tbsc_ctrl_props.sv
// Port checker of the DRAM controller top.
// Assumes it is bound onto tbsc_ctrl.
`default_nettype none
module tbsc_ctrl_props
  import tbsc_pkg::*;
(
  input wire logic              core_clk,
  input wire logic              rstn,
  input wire tbsc_host_in_type  host_in,
  input wire logic              brdy_n,
  input wire logic              next_address_n,
  input wire tbsc_dram_cmd_type dram_cmd,
  input wire tbsc_mux_ctl_type  mux_ctl,
  input wire logic [11:0]       mode_word
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  logic       cfg_q;
  wire  [3:0] cmd = dram_cmd;
  wire        mode_hit = !host_in.ads_n && host_in.addr[31:27] == 5'h1d && host_in.addr[5];
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) cfg_q <= 1'b0;
    else if (cmd == 4'b0000) cfg_q <= 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////////
  mode_seq_a:
    assert property (!cfg_q && mode_hit |-> ##2 cmd == 4'b0010 ##2 cmd == 4'b0000 ##2 !brdy_n)
    else $error("mode sequence wrong");
  cfg_gate_a:
    assert property (!cfg_q && cmd != 4'hf |-> cmd inside {4'b0010, 4'b0000})
    else $error("access before mode load");
  pre_a10_a:
    assert property (cmd == 4'b0010 |-> $past(mux_ctl.a10_high) && !$past(mux_ctl.load_mode))
    else $error("precharge without a10");
  load_mode_a:
    assert property (cmd == 4'b0000 |-> $past(mux_ctl.load_mode) && !$past(mux_ctl.a10_high) && mode_word == 12'h03a)
    else $error("mode load wrong");
  cmd_pulse_a:
    assert property (cmd != 4'hf |=> cmd != $past(cmd))
    else $error("command held too long");
  act_col_a:
    assert property (cmd == 4'b0011 |-> ##2 mux_ctl.col_sel ##1 cmd inside {4'b0101, 4'b0100})
    else $error("column command late");
  na_col_a:
    assert property ($fell(next_address_n) |-> ##1 cmd inside {4'b0101, 4'b0100})
    else $error("next address misplaced");
  rd_brdy_a:
    assert property (cmd == 4'b0101 |-> ##3 !brdy_n)
    else $error("read ready late");
  wr_brdy_a:
    assert property (cmd == 4'b0100 |-> !$past(brdy_n, 2))
    else $error("write ready late");
  ref_pre_a:
    assert property (cmd == 4'b0001 |-> $past(cmd, 2) == 4'b0010)
    else $error("refresh without precharge");
  cover property (cmd == 4'b0000);
  cover property (cmd == 4'b0001);
  cover property (cmd == 4'b0101 ##1 cmd == 4'hf);
endmodule : tbsc_ctrl_props
bind tbsc_ctrl tbsc_ctrl_props props_u (.core_clk, .rstn, .host_in, .brdy_n, .next_address_n, .dram_cmd,
  .mux_ctl, .mode_word);
`default_nettype wire

// File: verif/tbsc_ctrl_tb.sv
// Testbench: host bus, refresh and APB stimulus with cycle checks.
// Assumes the DRAM monitor model and the bound port checker.
`default_nettype none
module tbsc_ctrl_tb
  import tbsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic              core_clk = 1'b0;
  logic              rstn = 1'b0;
  tbsc_host_in_type  hin;
  logic              refresh_req;
  tbsc_apb_req_type  apb_q;
  tbsc_apb_rsp_type  apb_rsp;
  logic              brdy_n;
  logic              next_address_n;
  tbsc_dram_cmd_type dram_cmd;
  tbsc_mux_ctl_type  mux_ctl;
  logic [11:0]       mode_word;
  logic [11:0]       mode_q;
  logic [7:0]        ref_q;
  logic [31:0]       rd;
  logic              er;
  int                err_count = 0;
  int                checks = 0;
  int                fb, nb, fn;
  logic [31:0]       adr_t [4] = '{32'he000_0000, 32'he000_0020, 32'he000_0020, 32'he000_0000};
  int                fb_t [4] = '{7, 2, 7, 2};
  int                nb_t [4] = '{4, 4, 1, 1};
  always #4 core_clk = ~core_clk;
  tbsc_ctrl dut_u (.core_clk, .rstn, .host_in(hin), .refresh_req, .apb_req(apb_q), .apb_rsp, .brdy_n,
    .next_address_n, .dram_cmd, .dqm(), .mux_ctl, .mode_word);
  tbsc_dram_model dram_u (.core_clk, .rstn, .dram_cmd, .mux_ctl, .mode_word, .mode_q, .ref_q);
  ////////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_sim
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge core_clk);
    apb_q <= '{1'b1, 1'b0, w, a, d};
    @(posedge core_clk);
    apb_q.penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge core_clk);
      if (apb_rsp.pready === 1'b1) break;
    end
    rd = apb_rsp.prdata;
    er = apb_rsp.pslverr;
    apb_q <= '0;
    if (i == 16) begin
      err_count++;
      end_sim();
    end
  endtask : apb
  task automatic req(input logic [31:0] a, input logic w, input logic b);
    @(posedge core_clk);
    hin <= '{1'b0, a, w, !b, 8'h00, 1'b1};
  endtask : req
  // Edge 0 samples the strobe; a second strobe is driven at edge k2
  task automatic watch(input int n, input int k2, input logic [31:0] a2);
    fb = 0;
    nb = 0;
    fn = 0;
    for (int k = 0; k <= n; k++) begin
      @(posedge core_clk);
      hin.ads_n <= (k != k2);
      if (k == k2) hin.addr <= a2;
      #1;
      if (brdy_n === 1'b0) nb++;
      if (brdy_n === 1'b0 && fb == 0) fb = k;
      if (next_address_n === 1'b0 && fn == 0) fn = k;
    end
  endtask : watch
  initial begin
    hin = '{1'b1, 32'h0, 1'b0, 1'b1, 8'hff, 1'b1};
    refresh_req = 1'b0;
    apb_q = '0;
    repeat (16) @(posedge core_clk);
    rstn <= 1'b1;
    apb(1'b0, 8'h00, 32'h0);
    chk("ctrl reset", 32'h1, rd);
    apb(1'b0, 8'h04, 32'h0);
    chk("cfg before", 32'h0, rd[0]);
    req(32'he000_0000, 1'b0, 1'b1);
    watch(14, -1, 32'h0);
    chk("brdy before mode", 32'h0, nb);
    req(32'he800_0020, 1'b0, 1'b0);
    watch(10, -1, 32'h0);
    chk("mode brdy", 32'd5, fb);
    chk("mode word", 32'h03a, mode_q);
    apb(1'b0, 8'h04, 32'h0);
    chk("cfg after", 32'h1, rd[0]);
    $display("test config done");
    for (int i = 0; i < 4; i++) begin
      req(adr_t[i], i[0], i < 2);
      watch(14, -1, 32'h0);
      chk("first brdy", fb_t[i], fb);
      chk("brdy count", nb_t[i], nb);
      chk("next address", 32'd3, fn);
    end
    req(32'he000_0000, 1'b0, 1'b1);
    watch(24, 5, 32'he000_0020);
    chk("pipelined reads", 32'd8, nb);
    req(32'he000_0000, 1'b1, 1'b1);
    watch(24, 5, 32'he000_0020);
    chk("pipelined writes", 32'd8, nb);
    $display("test access done");
    @(posedge core_clk);
    refresh_req <= 1'b1;
    repeat (5) @(posedge core_clk);
    req(32'he000_0020, 1'b0, 1'b1);
    watch(30, -1, 32'h0);
    chk("refresh count", 32'h1, ref_q);
    chk("refresh first", 32'h1, fb > 7);
    chk("access after", 32'd4, nb);
    @(posedge core_clk);
    refresh_req <= 1'b0;
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b0, 8'h00, 32'h0);
    chk("ctrl written", 32'h0, rd);
    @(posedge core_clk);
    refresh_req <= 1'b1;
    repeat (20) @(posedge core_clk);
    chk("refresh gated", 32'h1, ref_q);
    apb(1'b0, 8'h08, 32'h0);
    chk("unmapped err", 32'h1, er);
    chk("unmapped data", 32'h0, rd);
    $display("test refresh and registers done");
    end_sim();
  end
endmodule : tbsc_ctrl_tb
`default_nettype wire
